// *** rtl/dcsp_params.svh ***
`ifndef DCSP_PARAMS_SVH
`define DCSP_PARAMS_SVH
`define DCSP_INSTR_RW_BIT    7
`define DCSP_INSTR_CNT_HI    6
`define DCSP_INSTR_CNT_LO    5
`define DCSP_INSTR_ADDR_HI   4
`define DCSP_REG_RESET       8'h00
`define DCSP_SEL_PLL_LOCK    3'h1
`define DCSP_SEL_DLL_LOCK    3'h2
`define DCSP_SEL_PATTERN_ERR 3'h3
`define DCSP_SEL_FIFO_ERR    3'h4
`define DCSP_SEL_SELFTEST    3'h5
`endif

// *** rtl/dcsp_pkg.sv ***
package dcsp_pkg;
	// Frame phase: instruction byte, then data bytes, then idle till enable rises
	typedef enum logic [2:0] {
		DCSP_INSTR = 3'b001,
		DCSP_DATA  = 3'b010,
		DCSP_DONE  = 3'b100
	} dcsp_phase_t;
endpackage

// *** rtl/dcsp_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin inputs
module dcsp_sync #(
	parameter int WIDTH = 3        // Number of bits
) (
	input  wire logic             clk_sys,  // System clock
	input  wire logic             sys_rst,  // Async reset, high
	input  wire logic [WIDTH-1:0] d_in,     // Asynchronous inputs
	output logic      [WIDTH-1:0] q_out     // Synchronised outputs
);
	logic [WIDTH-1:0] meta_ff;  // First stage, read only by second
	logic [WIDTH-1:0] sync_ff;  // Second stage

	// Both stages reset to zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule

// *** rtl/dcsp_serial_port.sv ***
`timescale 1ns/1ps
`include "dcsp_params.svh"
// Serial configuration port; registers kept in a local array
// Pins are sampled by the system clock, so each serial clock level
// must last at least three system cycles or edges are lost
module dcsp_serial_port #(
	parameter int ADDR_W = 5         // Register address width
) (
	input  wire logic             clk_sys,                   // 250 MHz system clock
	input  wire logic             sys_rst,                   // Async reset, high
	input  wire logic             serial_clk,                // Serial clock pin
	input  wire logic             frame_enable_n,            // Frame enable pin, active low
	input  wire logic             sdio_in,                   // Two-way data pin, input side
	output logic                  sdio_out,                  // Two-way data pin, output side
	output logic                  sdio_oe_n,                 // Two-way pin drive enable, low drives
	output logic                  serial_out_pin,            // Serial output pin level
	output logic                  serial_out_oe_n,           // Serial output drive enable, low drives
	input  wire logic             four_pin_select,           // Four-pin mode when high
	input  wire logic [2:0]       output_pin_source_select,  // Output pin source
	input  wire logic             pll_lock,                  // Status flag
	input  wire logic             dll_lock,                  // Status flag
	input  wire logic             pattern_err,               // Status flag
	input  wire logic             fifo_err,                  // Status flag
	input  wire logic             selftest_error_flag,       // Status flag
	output logic [(1<<ADDR_W)*8-1:0] reg_file                // All registers, flattened
);
	localparam int NREG = 1 << ADDR_W;  // Register count

	// Refuse address widths the instruction byte cannot hold;
	// checked at elaboration so a bad map never builds
	if (ADDR_W < 1 || ADDR_W > 5) begin : g_bad_addr_w
		$error("ADDR_W must be 1 to 5");
	end

	// Pin side and receive side
	logic [2:0] pin_s;           // Synchronised clk, enable, data
	logic       sclk_d_ff;       // Previous serial clock level
	logic [7:0] shift_ff;        // Incoming byte shifter
	logic [2:0] bit_ff;          // Bits taken in current byte
	logic [1:0] left_ff;         // Data bytes remaining minus one
	logic [4:0] addr_ff;         // Current register address
	logic       read_ff;         // Frame is a read
	// Transmit side and storage
	logic [7:0] rd_ff;           // Outgoing read byte
	logic       out_ff;          // Serial output level
	logic       drive_ff;        // Read data phase, output driving
	logic       tail_ff;         // Drive low after last read bit
	logic [7:0] regs [NREG];     // Register storage
	dcsp_pkg::dcsp_phase_t phase_ff;  // Frame phase

	// Pins cross into the system clock before use
	dcsp_sync #(.WIDTH(3)) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.d_in    ({serial_clk, frame_enable_n, sdio_in}),
		.q_out   (pin_s)
	);

	// Synchronised pin levels
	wire              sclk_s    = pin_s[2];               // Serial clock
	wire              en_n_s    = pin_s[1];               // Frame enable, active low
	wire              din_s     = pin_s[0];               // Two-way pin input

	// Serial clock edges, seen a few system cycles late
	wire              sclk_rise = sclk_s & ~sclk_d_ff;
	wire              sclk_fall = ~sclk_s & sclk_d_ff;

	// A bit is taken only on a rise inside a frame
	wire              take      = sclk_rise & ~en_n_s;
	wire              byte_end  = take && bit_ff == 3'h7; // Eighth bit of a byte
	wire [7:0]        byte_in   = {shift_ff[6:0], din_s};
	wire [ADDR_W-1:0] idx       = addr_ff[ADDR_W-1:0];    // Write index

	// Serial clock edge finder; resets to the idle low level
	// so that no false rise follows reset
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	// Bit shifter and counter; enable high drops partial bytes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shift_ff <= 8'h00;
			bit_ff   <= 3'h0;
		end else if (en_n_s) begin
			// Outside a frame: forget any partial byte
			shift_ff <= 8'h00;
			bit_ff   <= 3'h0;
		end else if (take) begin
			// MSB arrives first, so shift towards the top
			shift_ff <= byte_in;
			bit_ff   <= bit_ff + 3'h1;           // Wraps to zero after the eighth bit
		end
	end

	// Frame sequencing: instruction decode, count and address walk
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			phase_ff <= dcsp_pkg::DCSP_INSTR;
			left_ff  <= 2'h0;
			addr_ff  <= 5'h00;
			read_ff  <= 1'b0;
		end else if (en_n_s) begin
			// Every frame starts over with an instruction byte
			phase_ff <= dcsp_pkg::DCSP_INSTR;
			read_ff  <= 1'b0;
		end else if (byte_end) begin
			unique case (phase_ff)
				dcsp_pkg::DCSP_INSTR: begin
					// Direction, count and start address latch together
					read_ff  <= byte_in[`DCSP_INSTR_RW_BIT];
					left_ff  <= byte_in[`DCSP_INSTR_CNT_HI:`DCSP_INSTR_CNT_LO];
					addr_ff  <= byte_in[`DCSP_INSTR_ADDR_HI:0];
					phase_ff <= dcsp_pkg::DCSP_DATA;
				end
				dcsp_pkg::DCSP_DATA: begin
					// Walk down the map; address 0 wraps to the top
					addr_ff <= addr_ff - 5'h01;
					left_ff <= left_ff - 2'h1;
					if (left_ff == 2'h0) begin
						// Last counted byte: the rest of the frame is ignored
						phase_ff <= dcsp_pkg::DCSP_DONE;
					end
				end
				dcsp_pkg::DCSP_DONE: begin
					// Extra bytes past the count are ignored
				end
			endcase
		end
	end

	// Register writes land only on a complete data byte;
	// a read frame never writes, whatever the two-way pin shows
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= `DCSP_REG_RESET;
			end
		end else if (byte_end && phase_ff == dcsp_pkg::DCSP_DATA && !read_ff) begin
			regs[idx] <= byte_in;
		end
	end

	// Read fetch points: after a read instruction, and after every read
	// data byte that still has another one behind it
	wire              fetch_first = byte_end && phase_ff == dcsp_pkg::DCSP_INSTR && byte_in[`DCSP_INSTR_RW_BIT];
	wire              fetch_next  = byte_end && phase_ff == dcsp_pkg::DCSP_DATA && read_ff && left_ff != 2'h0;
	wire              read_last   = byte_end && phase_ff == dcsp_pkg::DCSP_DATA && read_ff && left_ff == 2'h0;
	wire              read_fall   = sclk_fall && phase_ff == dcsp_pkg::DCSP_DATA && read_ff;
	wire [ADDR_W-1:0] first_idx   = byte_in[ADDR_W-1:0];  // Start address of the frame
	wire [4:0]        next_addr   = addr_ff - 5'h01;      // Address of the following byte

	// Read shifter: load on the byte boundary, shift on falling edges.
	// The first bit leaves on the fall after the instruction's last rise,
	// so the host finds it settled at its next rise.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ff    <= 8'h00;
			out_ff   <= 1'b0;
			drive_ff <= 1'b0;
			tail_ff  <= 1'b0;
		end else if (en_n_s) begin
			// Frame closed: let go of the pins
			drive_ff <= 1'b0;
			tail_ff  <= 1'b0;
			out_ff   <= 1'b0;
		end else if (fetch_first) begin
			// Byte at the instruction's start address
			rd_ff <= regs[first_idx];
		end else if (fetch_next) begin
			// Byte at the next lower address
			rd_ff <= regs[next_addr[ADDR_W-1:0]];
		end else if (read_last) begin
			tail_ff <= 1'b1;
		end else if (read_fall) begin
			// One bit per falling edge, MSB first
			out_ff   <= rd_ff[7];
			rd_ff    <= {rd_ff[6:0], 1'b0};
			drive_ff <= 1'b1;
		end else if (sclk_fall && tail_ff) begin
			// Past the last bit the line is held low until the frame ends
			out_ff <= 1'b0;
		end
	end

	// Pin steering: host owns the two-way pin through the instruction byte
	always_comb begin
		logic stat_sel;
		logic stat_val;
		stat_sel = 1'b0;
		stat_val = 1'b0;
		// Codes 001 to 101 put a status flag on the output pin
		stat_sel = output_pin_source_select inside {[`DCSP_SEL_PLL_LOCK:`DCSP_SEL_SELFTEST]};
		unique case (output_pin_source_select)
			`DCSP_SEL_PLL_LOCK:    stat_val = pll_lock;
			`DCSP_SEL_DLL_LOCK:    stat_val = dll_lock;
			`DCSP_SEL_PATTERN_ERR: stat_val = pattern_err;
			`DCSP_SEL_FIFO_ERR:    stat_val = fifo_err;
			`DCSP_SEL_SELFTEST:    stat_val = selftest_error_flag;
			default:               stat_val = 1'b0;
		endcase
		sdio_out        = out_ff;
		// Only three-pin mode lets the device take the two-way pin
		sdio_oe_n       = !(drive_ff && !four_pin_select);
		if (stat_sel) begin
			// Status overrides read data, in either pin mode
			serial_out_pin  = stat_val;
			serial_out_oe_n = 1'b0;
		end else begin
			// Four-pin reads leave here; three-pin mode keeps it floating
			serial_out_pin  = out_ff;
			serial_out_oe_n = !(drive_ff && four_pin_select);
		end
	end

	// Flatten registers for the datapath; one slice per register
	for (genvar g = 0; g < NREG; g++) begin : g_flat
		assign reg_file[g*8 +: 8] = regs[g];
	end
endmodule

// *** tb/dcsp_assertions.sv ***
`timescale 1ns/1ps
// Port checks; pins pass a short synchroniser, hence settle counts
module dcsp_assertions #(
	parameter int ADDR_W = 5 // Address width
) (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Async reset
	input wire logic serial_clk, // Serial clock
	input wire logic frame_enable_n, // Frame enable
	input wire logic sdio_out, // Two-way pin value
	input wire logic sdio_oe_n, // Two-way pin enable
	input wire logic serial_out_pin, // Output pin
	input wire logic serial_out_oe_n, // Output pin enable
	input wire logic four_pin_select, // Mode
	input wire logic [2:0] output_pin_source_select, // Pin source
	input wire logic pll_lock, // Status flag
	input wire logic [(1<<ADDR_W)*8-1:0] reg_file // Registers
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	logic normal_sel; // Pin carries read data
	assign normal_sel = output_pin_source_select inside {3'h0, 3'h6, 3'h7};
	// Frame closes with ordinary routing
	sequence s_frame_end;
		$rose(frame_enable_n) ##0 normal_sel;
	endsequence
	a_idle_no_drive: assert property (frame_enable_n [*8] |-> sdio_oe_n)
		else $error("two-way pin driven outside frame");
	a_four_pin_in: assert property (four_pin_select [*8] |-> sdio_oe_n)
		else $error("two-way pin driven in four-pin mode");
	a_three_pin_float: assert property ((!four_pin_select && normal_sel) [*8] |-> serial_out_oe_n)
		else $error("output pin driven in three-pin mode");
	a_status_drive: assert property ((output_pin_source_select inside {[3'h1:3'h5]}) [*4] |-> !serial_out_oe_n)
		else $error("status not driven");
	a_pll_route: assert property ((output_pin_source_select == 3'h1 && $stable(pll_lock)) [*4] |-> serial_out_pin == pll_lock)
		else $error("lock flag not routed");
	a_oe_release: assert property (s_frame_end |-> ##[1:8] (serial_out_oe_n && sdio_oe_n))
		else $error("pins not released after frame");
	a_out_on_fall: assert property (!sdio_oe_n && $changed(sdio_out) |-> !serial_clk)
		else $error("read bit changed while clock high");
	a_write_on_rise: assert property ($changed(reg_file) |-> serial_clk && !frame_enable_n)
		else $error("register written off a rising bit");
endmodule
bind dcsp_serial_port dcsp_assertions #(.ADDR_W(ADDR_W)) dcsp_assertions_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.serial_clk(serial_clk), .frame_enable_n(frame_enable_n), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
	.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .four_pin_select(four_pin_select),
	.output_pin_source_select(output_pin_source_select), .pll_lock(pll_lock), .reg_file(reg_file));

// *** tb/dcsp_host.sv ***
`timescale 1ns/1ps
// Host model: 160 ns serial clock, still and low outside frames
module dcsp_host (
	output logic serial_clk, // Serial clock
	output logic frame_enable_n, // Frame enable
	output logic sdio_in, // Two-way wire level
	input wire logic sdio_out, // Device value
	input wire logic sdio_oe_n, // Device drives when low
	input wire logic serial_out_pin, // Output pin
	input wire logic four_pin_select // Mode
);
	logic hdrv; // Host drives wire
	logic hbit; // Host bit
	logic [31:0] rd; // Read bytes, right aligned
	logic tail; // Output pin after last fall
	// Released wire shows the inverse of the host bit
	assign sdio_in = !sdio_oe_n ? sdio_out : (hdrv ? hbit : ~hbit);
	initial begin
		serial_clk = 0;
		frame_enable_n = 1;
		hdrv = 1;
		hbit = 0;
	end
	// Frame of nb bits; short nb aborts mid-byte
	task automatic frame(input logic [7:0] ins, input logic [31:0] d, input int nb);
		logic [39:0] sh;
		sh = {ins, d};
		rd = '0;
		frame_enable_n = 0;
		for (int i = 0; i < nb; i++) begin
			hdrv = (i < 8) || !ins[7];
			hbit = sh[39 - i];
			#80 serial_clk = 1;
			if (i >= 8) rd = {rd[30:0], four_pin_select ? serial_out_pin : sdio_in};
			#80 serial_clk = 0;
		end
		#40 tail = serial_out_pin;
		#40 frame_enable_n = 1;
		hdrv = 1;
		#80;
	endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// Bench: table of write/readback rows, then abort and status cases
module testbench;
	logic clk_sys = 0; // System clock
	logic sys_rst = 1; // Reset
	logic four_pin_select = 0; // Mode
	logic [2:0] sel = 0; // Output pin source
	logic [4:0] st = 0; // Status flags
	logic serial_clk, frame_enable_n, sdio_in, sdio_out, sdio_oe_n, serial_out_pin, serial_out_oe_n;
	logic [255:0] reg_file; // Register bytes
	logic so_line; // Output pin wire, inverse level when released
	assign so_line = serial_out_oe_n ? ~serial_out_pin : serial_out_pin;
	int n_mismatch = 0; // Mismatches
	int checked = 0; // Comparisons
	// Mode, write instruction, data left aligned; last row wraps 1,0,31,30
	logic [40:0] rows [4] = '{{1'b0, 8'h05, 32'ha500_0000}, {1'b0, 8'h3f, 32'h3cc3_0000},
		{1'b1, 8'h4a, 32'h1234_5600}, {1'b1, 8'h61, 32'hdead_beef}};
	always #2 clk_sys = ~clk_sys;
	dcsp_serial_port dcsp_serial_port_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
		.frame_enable_n(frame_enable_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .four_pin_select(four_pin_select),
		.output_pin_source_select(sel), .pll_lock(st[0]), .dll_lock(st[1]), .pattern_err(st[2]),
		.fifo_err(st[3]), .selftest_error_flag(st[4]), .reg_file(reg_file));
	dcsp_host dcsp_host_inst (.serial_clk(serial_clk), .frame_enable_n(frame_enable_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out_pin(so_line),
		.four_pin_select(four_pin_select));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] ins;
		int n;
		repeat (6) @(negedge clk_sys);
		sys_rst = 0;
		chk({sdio_oe_n, serial_out_oe_n, |reg_file}, 3'b110);
		repeat (4) @(negedge clk_sys);
		foreach (rows[r]) begin
			four_pin_select = rows[r][40];
			ins = rows[r][39:32];
			n = ins[6:5] + 1;
			dcsp_host_inst.frame(ins, rows[r][31:0], 8 * n + 8);
			for (int k = 0; k < n; k++) chk(reg_file[8 * 5'(ins[4:0] - k) +: 8], rows[r][31 - 8 * k -: 8]);
			dcsp_host_inst.frame(ins | 8'h80, '0, 8 * n + 8);
			chk(dcsp_host_inst.rd, rows[r][31:0] >> (32 - 8 * n));
			if (four_pin_select) chk(dcsp_host_inst.tail, 0);
		end
		// Abort after four data bits, then a clean frame
		dcsp_host_inst.frame(8'h02, 32'hff00_0000, 12);
		chk(reg_file[23:16], 0);
		dcsp_host_inst.frame(8'h02, 32'h8100_0000, 16);
		chk(reg_file[23:16], 8'h81);
		// Output sources 1 to 7, two flag patterns
		for (int p = 0; p < 2; p++) begin
			st = p ? 5'h0a : 5'h15;
			for (int s = 1; s < 8; s++) begin
				sel = 3'(s);
				repeat (8) @(negedge clk_sys);
				if (s < 6) chk({serial_out_oe_n, serial_out_pin}, {1'b0, st[s - 1]});
				else chk(serial_out_oe_n, 1);
			end
		end
		sel = 0;
		sys_rst = 1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 0;
		chk({sdio_oe_n, serial_out_oe_n, |reg_file}, 3'b110);
		end_of_test;
	end
endmodule
